//--- est_timer.sv
// Eight/sixteen bit timer with input divider, output divider and event flag.
`timescale 1ns/1ps
`include "est_timer_regs.svh"

// Operation
// - Wide mode select picks 8 or 16 bits.
// - Count advances on divided source rising edges.
// - 8-bit mode compares low byte with shadow period.
// - On match clear low, refresh shadow period.
// - Zero period keeps output bit high.
// - 16-bit value is high byte over low.
// - In 16-bit mode a low byte read latches upper count byte.
// - High write buffers; low write loads it in 16-bit mode.
// - 16-bit counter wraps to zero, free running.
// - No automatic period reload in 16-bit mode.
// - Output toggles per match or wrap, divided.
// - Event flag set on toggle; interrupt when enabled.
// - Sixteen power-of-two input ratios, cleared by low and control writes.
// - Counts only while enable bit is one.
module est_timer
	import est_timer_pkg::*;
(
	// Clock, reset and clock enable
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// Selected timer clock source, synchronous to ref_clk
	input  wire logic       count_src,
	// Control register write
	input  wire logic       ctrl_wr,
	input  wire logic       timer_enable_bit,
	input  wire logic       wide_mode_select,
	input  wire logic [3:0] input_divider_select,
	input  wire logic [3:0] output_divider_select,
	// Count byte access
	input  wire logic       low_wr,
	input  wire logic       low_rd,
	input  wire logic       high_wr,
	input  wire logic [7:0] wr_data,
	// Event flag and interrupt
	input  wire logic       flag_clr,
	input  wire logic       int_enable,
	// Status
	output logic [7:0]      count_low_byte,
	output logic [7:0]      count_high_period_byte,
	output logic            timer_output_bit,
	output logic            timer_output_signal,
	output logic            timer_event_flag,
	output logic            timer_irq,
	output logic            enable_status,
	output logic            wide_status
);

	est_state_t s_q;
	est_state_t s_d;

	logic        src_rise;
	logic        tick;
	logic        match8;
	logic        wrap16;
	logic        cnt_event;
	logic        post_event;

	// Mask of the prescaler bits that must all be one for a 2^sel ratio.
	function automatic logic [14:0] presc_mask(input logic [3:0] sel);
		logic [15:0] m;
		m = (16'h0001 << sel) - 16'h0001;
		return m[14:0];
	endfunction

	always_comb
	begin
		s_d = s_q;
		src_rise = count_src & ~s_q.src_prev;
		tick = 1'b0;
		match8 = 1'b0;
		wrap16 = 1'b0;
		post_event = 1'b0;
		s_d.src_prev = count_src;
		if (s_q.enable && src_rise)
		begin
			s_d.presc = s_q.presc + `EST_PRESC_ONE;
			tick = ((s_q.presc & presc_mask(s_q.in_div)) == presc_mask(s_q.in_div));
		end
		match8 = tick && !s_q.wide && (s_q.count_low == s_q.shadow);
		wrap16 = tick && s_q.wide && (s_q.count_low == `EST_COUNT_MAX_8)
			&& (s_q.count_high == `EST_COUNT_MAX_8);
		cnt_event = match8 || wrap16;
		if (tick)
		begin
			if (!s_q.wide)
			begin
				if (match8)
				begin
					s_d.count_low = `EST_COUNT_ZERO;
					s_d.shadow = s_q.high_buf;
				end
				else
				begin
					s_d.count_low = s_q.count_low + 8'h01;
				end
			end
			else
			begin
				// Wrap falls out of the 16-bit add; nothing reloads the count.
				{s_d.count_high, s_d.count_low} = {s_q.count_high, s_q.count_low} + 16'h0001;
			end
		end
		// Output divider: every out_div+1 events toggle the output.
		if (cnt_event)
		begin
			if (s_q.post == s_q.out_div)
			begin
				s_d.post = `EST_POST_ZERO;
				post_event = 1'b1;
				s_d.out_bit = ~s_q.out_bit;
			end
			else
			begin
				s_d.post = s_q.post + `EST_POST_ONE;
			end
		end
		if (!s_q.wide && (s_q.high_buf == `EST_COUNT_ZERO))
		begin
			s_d.out_bit = 1'b1;
		end
		// Set wins over a clear in the same cycle.
		if (post_event)
		begin
			s_d.flag = 1'b1;
		end
		else if (flag_clr)
		begin
			s_d.flag = 1'b0;
		end
		if (low_rd && s_q.wide)
		begin
			s_d.high_buf = s_q.count_high;
		end
		if (high_wr)
		begin
			s_d.high_buf = wr_data;
		end
		if (low_wr)
		begin
			s_d.count_low = wr_data;
			if (s_q.wide)
			begin
				s_d.count_high = s_q.high_buf;
			end
			s_d.presc = `EST_PRESC_ZERO;
			s_d.post = `EST_POST_ZERO;
		end
		if (ctrl_wr)
		begin
			s_d.enable = timer_enable_bit;
			s_d.wide = wide_mode_select;
			s_d.in_div = input_divider_select;
			s_d.out_div = output_divider_select;
			s_d.presc = `EST_PRESC_ZERO;
			s_d.post = `EST_POST_ZERO;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_q.presc <= `EST_PRESC_ZERO;
			s_q.src_prev <= 1'b0;
			s_q.count_low <= `EST_COUNT_LOW_RST;
			s_q.count_high <= `EST_COUNT_ZERO;
			s_q.high_buf <= `EST_HIGH_PERIOD_RST;
			s_q.shadow <= `EST_HIGH_PERIOD_RST;
			s_q.post <= `EST_POST_ZERO;
			s_q.out_bit <= 1'b0;
			s_q.flag <= 1'b0;
			s_q.enable <= 1'b0;
			s_q.wide <= 1'b0;
			s_q.in_div <= `EST_DIV_SEL_RST;
			s_q.out_div <= `EST_DIV_SEL_RST;
		end
		else if (clk_en)
		begin
			s_q <= s_d;
		end
	end

	assign count_low_byte = s_q.count_low;
	assign count_high_period_byte = s_q.high_buf;
	assign timer_output_bit = s_q.out_bit;
	assign timer_output_signal = s_q.out_bit;
	assign timer_event_flag = s_q.flag;
	// Interrupt follows the sticky flag so a missed cycle cannot lose it.
	assign timer_irq = s_q.flag & int_enable;
	assign enable_status = s_q.enable;
	assign wide_status = s_q.wide;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	logic quiet;
	assign quiet = clk_en && !low_wr && !ctrl_wr && !high_wr;

	property p_wrap16;
		quiet && wrap16 |=> (s_q.count_low == 8'h00) && (s_q.count_high == 8'h00);
	endproperty
	a_wrap16: assert property (p_wrap16) else $error("16-bit count did not wrap to zero");

	property p_match8;
		quiet && match8 |=> (s_q.count_low == 8'h00) && (s_q.shadow == $past(s_q.high_buf));
	endproperty
	a_match8: assert property (p_match8) else $error("8-bit match did not clear and reload");

	property p_hold_disabled;
		quiet && !s_q.enable |=> $stable({s_q.count_high, s_q.count_low});
	endproperty
	a_hold_disabled: assert property (p_hold_disabled) else $error("count moved while disabled");

	property p_inc16;
		quiet && tick && s_q.wide |=>
			{s_q.count_high, s_q.count_low} == $past({s_q.count_high, s_q.count_low}) + 16'h0001;
	endproperty
	a_inc16: assert property (p_inc16) else $error("16-bit count did not advance by one");

	property p_rd_latch;
		clk_en && s_q.wide && low_rd && !high_wr |=> s_q.high_buf == $past(s_q.count_high);
	endproperty
	a_rd_latch: assert property (p_rd_latch) else $error("low read did not latch high byte");

	sequence s_high_then_low;
		clk_en && s_q.wide && high_wr && !low_wr && !ctrl_wr
			##1 clk_en && low_wr && !high_wr && !ctrl_wr;
	endsequence
	property p_buffered_high;
		s_high_then_low |=> s_q.count_high == $past(wr_data, 2);
	endproperty
	a_buffered_high: assert property (p_buffered_high) else $error("buffered high not loaded");

	property p_zero_period;
		clk_en && !s_q.wide && (s_q.high_buf == 8'h00) |=> s_q.out_bit;
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("zero period output not high");

	property p_flag_set;
		clk_en && post_event |=> s_q.flag && timer_irq == int_enable;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("event flag not set on toggle");

	property p_presc_clear;
		clk_en && (low_wr || ctrl_wr) |=> (s_q.presc == 15'h0000) && (s_q.post == 4'h0);
	endproperty
	a_presc_clear: assert property (p_presc_clear) else $error("divider count not cleared");

	property p_no_tick_disabled;
		!s_q.enable |-> !tick && !cnt_event;
	endproperty
	a_no_tick_disabled: assert property (p_no_tick_disabled) else $error("tick while disabled");

	// Toggle checks skip the zero-period force, which pins the bit high on its own.
	property p_toggle_div1;
		quiet && cnt_event && (s_q.out_div == 4'h0)
			&& !(!s_q.wide && (s_q.high_buf == 8'h00))
			|=> s_q.out_bit != $past(s_q.out_bit);
	endproperty
	a_toggle_div1: assert property (p_toggle_div1) else $error("no toggle on event");

	property p_inc8;
		quiet && tick && !s_q.wide && !match8
			|=> s_q.count_low == $past(s_q.count_low) + 8'h01;
	endproperty
	a_inc8: assert property (p_inc8) else $error("8-bit count did not advance");

	property p_flag_clear;
		clk_en && flag_clr && !post_event |=> !s_q.flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_shadow_hold;
		!(clk_en && match8) |=> $stable(s_q.shadow);
	endproperty
	a_shadow_hold: assert property (p_shadow_hold) else $error("shadow moved");

	property p_ctrl_load;
		clk_en && ctrl_wr |=> (s_q.enable == $past(timer_enable_bit))
			&& (s_q.wide == $past(wide_mode_select))
			&& (s_q.in_div == $past(input_divider_select));
	endproperty
	a_ctrl_load: assert property (p_ctrl_load) else $error("control not loaded");

	sequence s_read_then_idle;
		clk_en && s_q.wide && low_rd && !high_wr
			##1 clk_en && !high_wr && !(low_rd && s_q.wide);
	endsequence
	property p_read_hold;
		s_read_then_idle |=> s_q.high_buf == $past(s_q.count_high, 2);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("high latch not held");

	property p_high_hold;
		!(clk_en && (high_wr || (low_rd && s_q.wide))) |=> $stable(s_q.high_buf);
	endproperty
	a_high_hold: assert property (p_high_hold) else $error("high buffer moved");

	property p_presc_hold;
		quiet && !s_q.enable |=> $stable(s_q.presc);
	endproperty
	a_presc_hold: assert property (p_presc_hold) else $error("divider moved while off");

endmodule

//--- est_timer_pkg.sv
// Types shared by the eight/sixteen bit timer.
package est_timer_pkg;

	typedef struct packed {
		logic [14:0] presc;
		logic        src_prev;
		logic [7:0]  count_low;
		logic [7:0]  count_high;
		logic [7:0]  high_buf;
		logic [7:0]  shadow;
		logic [3:0]  post;
		logic        out_bit;
		logic        flag;
		logic        enable;
		logic        wide;
		logic [3:0]  in_div;
		logic [3:0]  out_div;
	} est_state_t;

endpackage

//--- est_timer_regs.svh
// Reset values and field constants of the eight/sixteen bit timer.
`ifndef EST_TIMER_REGS_SVH
`define EST_TIMER_REGS_SVH

`define EST_COUNT_LOW_RST     8'h00
`define EST_HIGH_PERIOD_RST   8'hFF
`define EST_COUNT_MAX_8       8'hFF
`define EST_COUNT_ZERO        8'h00
`define EST_DIV_SEL_RST       4'h0
`define EST_PRESC_ZERO        15'h0000
`define EST_PRESC_ONE         15'h0001
`define EST_POST_ZERO         4'h0
`define EST_POST_ONE          4'h1

`endif

//--- test_est_timer.sv
// Self-checking bench for the eight/sixteen bit timer.
`timescale 1ns/1ps
module test_est_timer;

	logic       ref_clk = '0, reset_n = '0, clk_en = 1'h1, count_src = '0, ctrl_wr = '0;
	logic       timer_enable_bit = '0, wide_mode_select = '0, low_wr = '0, low_rd = '0;
	logic       high_wr = '0, flag_clr = '0, int_enable = '0;
	logic [3:0] input_divider_select = '0, output_divider_select = '0;
	logic [7:0] wr_data = '0, count_low_byte, count_high_period_byte, m_low, m_high, m_up, m_sh;
	logic       timer_output_bit, timer_output_signal, timer_event_flag, timer_irq;
	logic       enable_status, wide_status, m_out, m_flag, m_en, m_wide;
	int         m_pc, m_post, m_div, m_odiv, err_total, n_checks, cyc;

	always #4 ref_clk = ~ref_clk;

	est_timer DUT (.ref_clk, .reset_n, .clk_en, .count_src, .ctrl_wr, .timer_enable_bit,
		.wide_mode_select, .input_divider_select, .output_divider_select, .low_wr, .low_rd,
		.high_wr, .wr_data, .flag_clr, .int_enable, .count_low_byte, .count_high_period_byte,
		.timer_output_bit, .timer_output_signal, .timer_event_flag, .timer_irq,
		.enable_status, .wide_status);

	task automatic chk();
		logic [21:0] e, a;
		// A zero period holds the output register high, so the model follows it.
		if (!m_wide && m_high == '0)
			m_out = 1'h1;
		e = {m_low, m_high, m_out, m_out, m_flag, m_flag & int_enable, m_en, m_wide};
		a = {count_low_byte, count_high_period_byte, timer_output_bit, timer_output_signal,
			timer_event_flag, timer_irq, enable_status, wide_status};
		n_checks++;
		if (a !== e)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask

	// Strobes: 0 control, 1 low write, 2 high write, 3 low read, 4 flag clear.
	task automatic op(input int k, input logic [7:0] d);
		@(negedge ref_clk);
		wr_data = d;
		{ctrl_wr, low_wr, high_wr, low_rd, flag_clr} = 5'h10 >> k;
		@(negedge ref_clk);
		{ctrl_wr, low_wr, high_wr, low_rd, flag_clr} = '0;
		case (k)
			0:
			begin
				m_en = timer_enable_bit;
				m_wide = wide_mode_select;
				m_div = int'(input_divider_select);
				m_odiv = int'(output_divider_select);
				{m_pc, m_post} = 64'h0;
			end
			1: {m_low, m_up, m_pc, m_post} = {d, m_wide ? m_high : m_up, 64'h0};
			2: m_high = d;
			3: m_high = m_wide ? m_up : m_high;
			default: m_flag = '0;
		endcase
		// One more edge lets the zero-period force reach the output bit.
		@(negedge ref_clk);
		chk();
	endtask

	task automatic evt();
		if (m_post == m_odiv)
			{m_post, m_out, m_flag} = {32'h0, ~m_out, 1'h1};
		else
			m_post++;
	endtask

	task automatic rise();
		@(negedge ref_clk);
		count_src = 1'h1;
		@(negedge ref_clk);
		count_src = '0;
		@(negedge ref_clk);
		if (m_en && clk_en && ++m_pc >= (1 << m_div))
		begin
			m_pc = 0;
			if (m_wide)
			begin
				{m_up, m_low} = {m_up, m_low} + 16'h0001;
				if ({m_up, m_low} == '0)
					evt();
			end
			else if (m_low == m_sh)
			begin
				{m_low, m_sh} = {8'h00, m_high};
				evt();
			end
			else
				m_low++;
		end
		chk();
	endtask

	task final_report();
		$display("Checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge ref_clk)
		if (++cyc > 4000)
		begin
			err_total++;
			final_report();
		end

	initial
	begin
		void'($urandom(32'h684a_c4aa));
		{m_low, m_high, m_sh, m_up} = 32'h00ff_ff00;
		{m_out, m_flag, m_en, m_wide, m_pc, m_post, m_div, m_odiv} = '0;
		repeat (2) @(negedge ref_clk);
		reset_n = 1'h1;
		chk();
		int_enable = 1'h1;
		timer_enable_bit = 1'h1;
		op(2, 8'h02);
		op(0, 8'h00);
		op(1, 8'hff);
		repeat (7) rise();
		op(4, 8'h00);
		output_divider_select = 4'h1;
		op(0, 8'h00);
		repeat (6) rise();
		op(2, 8'h00);
		$display("period test done");
		wide_mode_select = 1'h1;
		output_divider_select = '0;
		op(0, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			op(2, (i == 0) ? 8'hff : 8'($urandom));
			op(1, 8'hfe);
			repeat (3) rise();
			op(3, 8'h00);
		end
		$display("wide test done");
		for (int s = 0; s < 5; s++)
		begin
			input_divider_select = 4'(s);
			op(0, 8'h00);
			repeat (2 * (1 << s) + 1) rise();
		end
		$display("divider test done");
		int_enable = '0;
		input_divider_select = '0;
		timer_enable_bit = '0;
		op(0, 8'h00);
		repeat (2) rise();
		timer_enable_bit = 1'h1;
		op(0, 8'h00);
		clk_en = '0;
		rise();
		clk_en = 1'h1;
		rise();
		$display("enable test done");
		final_report();
	end

endmodule
